// ===== rtl/abx_cfg.svh
// register map, instruction fields, reset values of the exec unit
`ifndef ABX_CFG_SVH
`define ABX_CFG_SVH

`define ABX_ACC_OFS 8'h00
`define ABX_STAT_OFS 8'h04
`define ABX_FADDR_OFS 8'h08
`define ABX_FDATA_OFS 8'h0c
`define ABX_SKIP_OFS 8'h10
`define ABX_LAST_OFS 8'h14

`define ABX_C_BIT 0
`define ABX_DC_BIT 1
`define ABX_Z_BIT 2

`define ABX_ACC_RST 8'h00
`define ABX_STAT_RST 3'h0
`define ABX_FADDR_RST 7'h00
`define ABX_PORT_RST 8'h00
`define ABX_PORT_ADDR 7'h05

`define ABX_DEST_BIT 7
`define ABX_OPC_ADD_REG 6'h07
`define ABX_OPC_AND_REG 6'h05
`define ABX_OPC_AND_LIT 6'h39
`define ABX_OPC_ADD_LIT 5'h1f
`define ABX_CLASS_BIT 2'h1

`define ABX_RESP_OKAY 2'h0
`define ABX_RESP_SLVERR 2'h2

`endif

// ===== rtl/abx_pkg.sv
// types shared by the exec unit modules
package abx_pkg;

    typedef enum logic [3:0] {
        ABX_OP_NONE,
        ABX_OP_ADD_LIT,
        ABX_OP_ADD_REG,
        ABX_OP_AND_LIT,
        ABX_OP_AND_REG,
        ABX_OP_BCLR,
        ABX_OP_BSET,
        ABX_OP_TST_LO,
        ABX_OP_TST_HI
    } abx_op_t;

endpackage : abx_pkg

// ===== rtl/abx_alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/1ns
interface abx_alu_if;
    abx_pkg::abx_op_t op;
    logic [7:0] acc;
    logic [7:0] operand;
    logic [2:0] bitpos;
    logic [7:0] result;
    logic carry;
    logic half;
    logic zero;
    logic bit_val;

    modport core (
        output op, acc, operand, bitpos,
        input result, carry, half, zero, bit_val
    );
    modport alu (
        input op, acc, operand, bitpos,
        output result, carry, half, zero, bit_val
    );
endinterface : abx_alu_if

// ===== rtl/abx_alu.sv
// combinational add, and, bit set/clear and bit test
`timescale 1ns/1ns
module abx_alu (
    abx_alu_if.alu a
);
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] mask;

    assign low_sum = {1'b0, a.acc[3:0]} + {1'b0, a.operand[3:0]};
    assign full_sum = {1'b0, a.acc} + {1'b0, a.operand};
    assign mask = 8'h01 << a.bitpos;

    always_comb begin
        a.result = a.operand;
        a.carry = 1'b0;
        a.half = 1'b0;
        case (a.op)
            abx_pkg::ABX_OP_ADD_LIT,
            abx_pkg::ABX_OP_ADD_REG: begin
                a.result = full_sum[7:0];
                a.carry = full_sum[8];
                a.half = low_sum[4];
            end
            abx_pkg::ABX_OP_AND_LIT,
            abx_pkg::ABX_OP_AND_REG: begin
                a.result = a.acc & a.operand;
            end
            abx_pkg::ABX_OP_BCLR: begin
                a.result = a.operand & ~mask;
            end
            abx_pkg::ABX_OP_BSET: begin
                a.result = a.operand | mask;
            end
            default: begin
                a.result = a.operand;
            end
        endcase
    end

    assign a.zero = (a.result == 8'h00);
    assign a.bit_val = a.operand[a.bitpos];
endmodule : abx_alu

// ===== rtl/abx_exec_unit.sv
// add, and and bit test execution unit with its axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "abx_cfg.svh"

module abx_exec_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_latch,
    output logic [7:0] acc_out,
    output logic [2:0] flags_out,
    output logic skip_next,
    output logic discard_pulse,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int FILE_DEPTH = 128;

    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] acc_q;
    logic [2:0] stat_q;
    logic [6:0] faddr_q;
    logic [7:0] port_q;
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic skip_pend_q;
    logic discard_q;
    logic [3:0] last_op_q;
    logic [7:0] discard_cnt_q;

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    abx_alu_if alu_bus ();

    abx_alu u_alu (
        .a(alu_bus.alu)
    );

    // instruction word split into its fields
    function automatic abx_pkg::abx_op_t decode_op(input logic [13:0] w);
        abx_pkg::abx_op_t op;
        op = abx_pkg::ABX_OP_NONE;
        if (w[13:8] == `ABX_OPC_ADD_REG) begin
            op = abx_pkg::ABX_OP_ADD_REG;
        end else if (w[13:8] == `ABX_OPC_AND_REG) begin
            op = abx_pkg::ABX_OP_AND_REG;
        end else if (w[13:8] == `ABX_OPC_AND_LIT) begin
            op = abx_pkg::ABX_OP_AND_LIT;
        end else if (w[13:9] == `ABX_OPC_ADD_LIT) begin
            op = abx_pkg::ABX_OP_ADD_LIT;
        end else if (w[13:12] == `ABX_CLASS_BIT) begin
            case (w[11:10])
                2'h0: op = abx_pkg::ABX_OP_BCLR;
                2'h1: op = abx_pkg::ABX_OP_BSET;
                2'h2: op = abx_pkg::ABX_OP_TST_LO;
                default: op = abx_pkg::ABX_OP_TST_HI;
            endcase
        end
        return op;
    endfunction : decode_op

    // the port address always reads the synchronised pin levels
    function automatic logic [7:0] read_file(input logic [6:0] addr);
        logic [7:0] v;
        v = file_mem[addr];
        if (addr == `ABX_PORT_ADDR) begin
            v = pin_sync_q;
        end
        return v;
    endfunction : read_file

    function automatic logic addr_mapped(input logic [7:0] addr);
        return addr == `ABX_ACC_OFS || addr == `ABX_STAT_OFS ||
            addr == `ABX_FADDR_OFS || addr == `ABX_FDATA_OFS ||
            addr == `ABX_SKIP_OFS || addr == `ABX_LAST_OFS;
    endfunction : addr_mapped

    abx_pkg::abx_op_t op;
    logic take;
    logic is_lit;
    logic is_byte;
    logic dest_file;
    logic [6:0] f_addr;
    logic to_acc;
    logic to_file;
    logic upd_all;
    logic upd_z;
    logic skip_hit;
    logic wr_go;
    logic wr_lane;

    assign op = decode_op(instr_word);
    assign take = instr_valid && !skip_pend_q;
    assign f_addr = instr_word[6:0];
    assign dest_file = instr_word[`ABX_DEST_BIT];
    assign is_lit = op == abx_pkg::ABX_OP_ADD_LIT ||
        op == abx_pkg::ABX_OP_AND_LIT;
    assign is_byte = op == abx_pkg::ABX_OP_ADD_REG ||
        op == abx_pkg::ABX_OP_AND_REG;
    assign to_acc = take && (is_lit || (is_byte && !dest_file));
    assign to_file = take && ((is_byte && dest_file) ||
        op == abx_pkg::ABX_OP_BCLR || op == abx_pkg::ABX_OP_BSET);
    assign upd_all = take && (op == abx_pkg::ABX_OP_ADD_LIT ||
        op == abx_pkg::ABX_OP_ADD_REG);
    assign upd_z = take && (op == abx_pkg::ABX_OP_AND_LIT ||
        op == abx_pkg::ABX_OP_AND_REG);
    assign skip_hit = take &&
        ((op == abx_pkg::ABX_OP_TST_LO && !alu_bus.bit_val) ||
        (op == abx_pkg::ABX_OP_TST_HI && alu_bus.bit_val));

    assign alu_bus.op = op;
    assign alu_bus.acc = acc_q;
    // a process, not an assign, so file and pin changes reach the operand
    always_comb begin
        alu_bus.operand = read_file(f_addr);
        if (is_lit) begin
            alu_bus.operand = instr_word[7:0];
        end
    end
    assign alu_bus.bitpos = instr_word[9:7];

    assign wr_go = !awready_q && !wready_q && !bvalid_q;
    assign wr_lane = wr_go && wstrb_q[0];

    // pins pass two flip-flops before any use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= port_pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // accumulator: executed instruction beats a bus write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= `ABX_ACC_RST;
        end else if (to_acc) begin
            acc_q <= alu_bus.result;
        end else if (wr_lane && awaddr_q == `ABX_ACC_OFS) begin
            acc_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `ABX_STAT_RST;
        end else if (upd_all) begin
            stat_q[`ABX_C_BIT] <= alu_bus.carry;
            stat_q[`ABX_DC_BIT] <= alu_bus.half;
            stat_q[`ABX_Z_BIT] <= alu_bus.zero;
        end else if (upd_z) begin
            stat_q[`ABX_Z_BIT] <= alu_bus.zero;
        end else if (wr_lane && awaddr_q == `ABX_STAT_OFS) begin
            stat_q <= wdata_q[2:0];
        end
    end

    // file registers; the port address goes to the output latch
    always_ff @(posedge clk) begin
        if (to_file && f_addr != `ABX_PORT_ADDR) begin
            file_mem[f_addr] <= alu_bus.result;
        end else if (wr_lane && awaddr_q == `ABX_FDATA_OFS &&
            faddr_q != `ABX_PORT_ADDR) begin
            file_mem[faddr_q] <= wdata_q[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_q <= `ABX_PORT_RST;
        end else if (to_file && f_addr == `ABX_PORT_ADDR) begin
            port_q <= alu_bus.result;
        end else if (wr_lane && awaddr_q == `ABX_FDATA_OFS &&
            faddr_q == `ABX_PORT_ADDR) begin
            port_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faddr_q <= `ABX_FADDR_RST;
        end else if (wr_lane && awaddr_q == `ABX_FADDR_OFS) begin
            faddr_q <= wdata_q[6:0];
        end
    end

    // skip: the next offered instruction runs as an idle cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_pend_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            discard_q <= instr_valid && skip_pend_q;
            if (instr_valid && skip_pend_q) begin
                skip_pend_q <= 1'b0;
            end else if (skip_hit) begin
                skip_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_op_q <= 4'h0;
            discard_cnt_q <= 8'h00;
        end else begin
            if (take) begin
                last_op_q <= op;
            end
            if (instr_valid && skip_pend_q) begin
                discard_cnt_q <= discard_cnt_q + 8'h01;
            end
        end
    end

    // axi write channel: address and data in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `ABX_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_mapped(awaddr_q) ?
                    `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // axi read channel: data one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `ABX_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= addr_mapped(s_axi_araddr) ?
                `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
            case (s_axi_araddr)
                `ABX_ACC_OFS: rdata_q <= {24'h00_0000, acc_q};
                `ABX_STAT_OFS: rdata_q <= {29'h0000_0000, stat_q};
                `ABX_FADDR_OFS: rdata_q <= {25'h000_0000, faddr_q};
                `ABX_FDATA_OFS: rdata_q <= {24'h00_0000, read_file(faddr_q)};
                `ABX_SKIP_OFS: rdata_q <= {16'h0000, discard_cnt_q,
                    7'h00, skip_pend_q};
                `ABX_LAST_OFS: rdata_q <= {28'h000_0000, last_op_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign port_latch = port_q;
    assign acc_out = acc_q;
    assign flags_out = stat_q;
    assign skip_next = skip_pend_q;
    assign discard_pulse = discard_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule : abx_exec_unit

// ===== verif/abx_exec_unit_asserts.sv
// port assertions of the exec unit
`timescale 1ns/1ns
module abx_exec_unit_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] acc_out,
    input wire logic [2:0] flags_out,
    input wire logic skip_next,
    input wire logic discard_pulse,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic idle;
    logic take;
    logic [8:0] sum;
    logic [4:0] hs;
    logic [7:0] msk;
    logic [1:0] age_q;
    // no register write can land on the edge while both readys are high
    assign idle = s_axi_awready && s_axi_wready;
    assign take = instr_valid && !skip_next && idle;
    assign sum = {1'b0, acc_out} + {1'b0, instr_word[7:0]};
    assign hs = {1'b0, acc_out[3:0]} + {1'b0, instr_word[3:0]};
    assign msk = 8'h01 << instr_word[9:7];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // pins steady long enough to have crossed the synchroniser
    sequence pins_held;
        age_q == 2'h3 && $stable(port_pin_in)
            && port_pin_in == $past(port_pin_in, 2)
            && port_pin_in == $past(port_pin_in, 3);
    endsequence
    reset_val_a: assert property ($rose(rst_n) |-> acc_out == 8'h00
        && flags_out == 3'h0 && !skip_next && port_latch == 8'h00)
        else $error("state not cleared by reset");
    add_lit_a: assert property (
        take && instr_word[13:9] == 5'h1f |=> acc_out == $past(sum[7:0])
        && flags_out == $past({sum[7:0] == 8'h00, hs[4], sum[8]}))
        else $error("add immediate result or flags wrong");
    and_lit_a: assert property (
        take && instr_word[13:8] == 6'h39 |=> flags_out[2] == !(|acc_out)
        && acc_out == $past(acc_out & instr_word[7:0])
        && flags_out[1:0] == $past(flags_out[1:0]))
        else $error("and immediate result or flags wrong");
    bit_flags_a: assert property (
        take && instr_word[13:12] == 2'h1 |=> $stable(flags_out)
        && $stable(acc_out)) else $error("bit op touched acc or flags");
    port_rmw_a: assert property (
        take && instr_word[13:11] == 3'h2 && instr_word[6:0] == 7'h05
        ##0 pins_held |=> port_latch == $past(instr_word[10] ?
        port_pin_in | msk : port_pin_in & ~msk))
        else $error("port bit op not based on pins");
    test_skip_a: assert property (
        take && instr_word[13:11] == 3'h3 && instr_word[6:0] == 7'h05
        ##0 pins_held |=> skip_next == $past(port_pin_in[instr_word[9:7]]
        == instr_word[10])) else $error("bit test skip decision wrong");
    discard_a: assert property (
        skip_next && instr_valid && idle |=> !skip_next && discard_pulse
        && $stable(acc_out) && $stable(flags_out) && $stable(port_latch))
        else $error("discarded instruction had an effect");
    pulse_src_a: assert property (
        discard_pulse |-> $past(skip_next) && $past(instr_valid))
        else $error("discard pulse without a discarded word");
    skip_hold_a: assert property (
        skip_next && !instr_valid |=> skip_next)
        else $error("pending skip lost before next word");
    add_seen_c: cover property (take && instr_word[13:9] == 5'h1f);
    skip_seen_c: cover property (skip_next && instr_valid);
    hold_seen_c: cover property (skip_next && !instr_valid);
endmodule : abx_exec_unit_asserts

bind abx_exec_unit abx_exec_unit_asserts i_chk (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .port_pin_in(port_pin_in), .port_latch(port_latch), .acc_out(acc_out),
    .flags_out(flags_out), .skip_next(skip_next),
    .discard_pulse(discard_pulse), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready));

// ===== verif/abx_fetch_model.sv
// behavioural fetch stage handing instruction words to the exec unit
`timescale 1ns/1ns
module abx_fetch_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic instr_valid,
    output logic [13:0] instr_word
);
    logic [12:0] pc_q;
    initial begin
        instr_valid = 1'b0;
        instr_word = 14'h0000;
    end
    // the counter moves on for a discarded word as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= 13'h0000;
        end else if (instr_valid) begin
            pc_q <= pc_q + 13'h0001;
        end
    end
    // words go out back to back; the released word is scrambled
    task automatic run(input logic [13:0] q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            instr_valid <= 1'b1;
            instr_word <= q[i];
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
    endtask : run
endmodule : abx_fetch_model

// ===== verif/abx_exec_unit_tb.sv
// self-checking bench of the add, and and bit test exec unit
`timescale 1ns/1ns
module abx_exec_unit_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid;
    logic [13:0] instr_word;
    logic [7:0] pins = 8'h00;
    logic [7:0] port_latch, acc_out, awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] flags_out;
    logic skip_next, discard_pulse, sk;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] wdata = 32'h0, rdata, rdv;
    logic [55:0] r;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // word, acc in, flags in, file in, acc out, flags out, file out
    logic [55:0] rows [13] = '{
        56'h3e01_ff_0_00_00_7_00, 56'h3f08_08_0_00_10_2_00,
        56'h3eff_02_4_00_01_3_00, 56'h0720_10_7_25_35_0_25,
        56'h07a0_90_0_80_90_1_10, 56'h07a0_01_0_ff_01_7_00,
        56'h390f_f5_3_00_05_3_00, 56'h39f0_0f_3_00_00_7_00,
        56'h0520_f0_3_3c_30_3_3c, 56'h05a0_0f_0_f0_0f_4_00,
        56'h13a0_5a_5_ff_5a_5_7f, 56'h1420_5a_2_00_5a_2_01,
        56'h0000_5a_2_33_5a_2_33};
    logic [13:0] tw [4] = '{14'h1885, 14'h1805, 14'h1c05, 14'h1c85};

    abx_fetch_model i_fetch (.clk(clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word));
    abx_exec_unit i_dut (.clk(clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .port_pin_in(pins), .port_latch(port_latch), .acc_out(acc_out),
        .flags_out(flags_out), .skip_next(skip_next),
        .discard_pulse(discard_pulse), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic cmp(input logic [39:0] got, input logic [39:0] exp,
        input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what,
                got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        rsp = rresp;
    endtask : rd

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp(acc_out, 8'h00, "acc reset");
        cmp(flags_out, 3'h0, "flags reset");
        cmp(port_latch, 8'h00, "latch reset");
        cmp(skip_next, 1'b0, "skip reset");
        wr(8'h40, 32'h1);
        cmp(rsp, 2'h2, "bresp unmapped");
        rd(8'h40);
        cmp({rsp, rdv}, {2'h2, 32'h0}, "read unmapped");
        @(posedge clk);
        wstrb <= 4'h0;
        wr(8'h00, 32'hff);
        wstrb <= 4'hf;
        @(negedge clk);
        cmp(acc_out, 8'h00, "strobe off");
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'h08, 32'h20);
            wr(8'h0c, {24'h0, r[27:20]});
            wr(8'h00, {24'h0, r[39:32]});
            wr(8'h04, {29'h0, r[30:28]});
            i_fetch.run('{r[53:40]});
            @(negedge clk);
            cmp(acc_out, r[19:12], "acc");
            cmp(flags_out, r[10:8], "flags");
            rd(8'h0c);
            cmp(rdv, r[7:0], "file");
        end
        @(posedge clk);
        pins <= 8'ha5;
        repeat (4) @(posedge clk);
        i_fetch.run('{14'h1485});
        @(negedge clk);
        cmp(port_latch, 8'ha7, "port set");
        i_fetch.run('{14'h1005});
        @(negedge clk);
        cmp(port_latch, 8'ha4, "port clear");
        foreach (tw[i]) begin
            wr(8'h00, 32'h10);
            wr(8'h04, 32'h4);
            sk = pins[tw[i][9:7]] == tw[i][10];
            if (i[1]) begin
                i_fetch.run('{tw[i]});
                i_fetch.run('{14'h3e01});
            end else begin
                i_fetch.run('{tw[i], 14'h3e01});
            end
            @(negedge clk);
            cmp(acc_out, sk ? 8'h10 : 8'h11, "acc");
            cmp(flags_out, sk ? 3'h4 : 3'h0, "flags");
            cmp(discard_pulse, sk, "pulse");
            cmp(skip_next, 1'b0, "skip");
        end
        rd(8'h00);
        cmp({rsp, rdv}, {2'h0, 32'h0000_0011}, "acc read");
        rd(8'h10);
        cmp({rsp, rdv}, {2'h0, 32'h0000_0200}, "discards");
        rd(8'h14);
        cmp(rdv, 32'(abx_pkg::ABX_OP_ADD_LIT), "last op");
        cmp(i_fetch.pc_q, 13'h0017, "pc");
        // same word twice: the second must see the first one's result
        wr(8'h0c, 32'h01);
        cmp(rsp, 2'h0, "bresp okay");
        wr(8'h00, 32'h02);
        i_fetch.run('{14'h07a0, 14'h07a0});
        @(negedge clk);
        cmp(acc_out, 8'h02, "acc chain");
        cmp(flags_out, 3'h0, "flags chain");
        rd(8'h0c);
        cmp(rdv, 32'h0000_0005, "file chain");
        // reset in mid-run with a skip pending
        i_fetch.run('{tw[0]});
        @(negedge clk);
        cmp(skip_next, 1'b1, "skip pending");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp({acc_out, flags_out, port_latch}, 19'h0, "mid reset");
        cmp({skip_next, discard_pulse}, 2'h0, "skip mid reset");
        wr(8'h00, 32'h5a);
        @(negedge clk);
        cmp({rsp, acc_out}, {2'h0, 8'h5a}, "write after reset");
        end_of_test();
    end
endmodule : abx_exec_unit_tb
